// ---- inc/icm_pkg.sv ----
package icm_pkg;
  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [1:0] CTRL_ONE_IDX  = 2'h0;
  localparam logic [1:0] CTRL_TWO_IDX  = 2'h1;
  localparam logic [1:0] XFER_MODE_IDX = 2'h2;
  localparam logic [1:0] IRQ_EN_IDX    = 2'h3;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ICE_BIT    = 7;
  localparam int RCVD_BIT   = 6;
  localparam int MST_BIT    = 5;
  localparam int TRS_BIT    = 4;
  localparam int BUS_BUSY_FLAG_BIT   = 7;
  localparam int SCP_BIT    = 6;
  localparam int SDA_DRIVE_VALUE_BIT   = 5;
  localparam int SDA_DRIVE_WRITE_GUARD_BIT  = 4;
  localparam int RST_BIT    = 1;
  localparam int MLS_BIT    = 7;
  localparam int COUNT_WRITE_GUARD_BIT   = 3;
  localparam int TIE_BIT    = 7;
  localparam int TX_END_IRQ_ENABLE_BIT   = 6;
  localparam int RIE_BIT    = 5;
  // ---------------------------------------------------------------
  // reset values and fixed read bits
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST  = 8'h7d;
  localparam logic [7:0] XFER_MODE_RST = 8'h38;
  localparam logic [7:0] IRQ_EN_RST    = 8'h00;
  localparam logic [2:0] BC_CLEAR      = 3'h0;
  localparam logic [2:0] BC_ONE        = 3'h1;
  localparam logic [1:0] MODE_SLV_RX   = 2'h0;
  localparam logic [1:0] MODE_SLV_TX   = 2'h1;
  localparam logic [1:0] MODE_MST_RX   = 2'h2;
  localparam logic [1:0] MODE_MST_TX   = 2'h3;
  // transfer clock divisors for codes 0 to 15, in peripheral clocks
  localparam logic [9:0] DIV_TABLE [16] = '{10'd28, 10'd40, 10'd48, 10'd64, 10'd80, 10'd100, 10'd112, 10'd128,
                                            10'd112, 10'd160, 10'd192, 10'd256, 10'd320, 10'd400, 10'd448, 10'd512};
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PH_IDLE  = 4'h1,
    PH_START = 4'h2,
    PH_RUN   = 4'h4,
    PH_STOP  = 4'h8
  } icm_phase_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } icm_bus_req_t;
  typedef struct packed {
    logic tx_empty;
    logic tx_end;
    logic rx_full;
    logic overrun;
  } icm_flags_t;
endpackage

// ---- design/icm_ctrl.sv ----
`timescale 1ns/1ps
module icm_ctrl (
  input  wire logic                 clk_in,          // peripheral clock, 40 MHz
  input  wire logic                 reset_n_in,      // power-on reset
  input  wire icm_pkg::icm_bus_req_t bus_in,         // register access
  output logic [7:0]                rdata_out,       // read data, cycle after strobe
  input  wire logic                 format_select_in, // 0 I2C, 1 clocked sync
  input  wire logic [6:0]           own_address_in,  // programmed slave address
  input  wire logic                 addr_byte_in,    // pulse: first byte after start done
  input  wire logic [7:0]           rx_byte_in,      // received first byte
  input  wire logic                 arb_lost_in,     // pulse: arbitration lost
  input  wire logic                 overrun_in,      // pulse: overrun error
  input  wire logic                 standby_in,      // software or module standby
  input  wire icm_pkg::icm_flags_t  flags_in,        // status flags
  input  wire logic                 scl_in,          // SCL pin level
  output logic                      scl_out,         // SCL drive value
  output logic                      scl_oe_out,      // SCL drive enable
  input  wire logic                 sda_in,          // SDA pin level
  output logic                      sda_out,         // SDA drive value
  output logic                      sda_oe_out,      // SDA drive enable
  output logic [1:0]                mode_out,        // master/transmit mode code
  output logic                      lsb_first_out,   // bit order to shifter
  output logic [2:0]                bit_count_out,   // remaining bits
  output logic                      tx_empty_irq_out, // tx empty request
  output logic                      tx_end_irq_out,  // tx end request
  output logic                      rx_full_irq_out, // rx full request
  output logic                      error_irq_out    // overrun request
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                interface_enable;
    logic                rcvd;
    logic                master_select;
    logic                transmit_select;
    logic [3:0]          cks;
    logic                bus_busy_flag;
    logic                sda_drive_value;
    logic                rst;
    logic                lsb_first_select;
    logic [2:0]          bc;
    logic                tx_empty_irq_enable;
    logic                tx_end_irq_enable;
    logic                rx_full_irq_enable;
    logic                fs;
    icm_pkg::icm_phase_t phase;
    logic [8:0]          cnt;
    logic                scl_lvl;
    logic                sda_lvl;
    logic                scl_s1;
    logic                scl_s2;
    logic                scl_d;
    logic                sda_s1;
    logic                sda_s2;
    logic                sda_d;
    logic [7:0]          rdata;
    logic                scl_o;
    logic                scl_oe;
    logic                sda_oe;
    logic [3:0]          irq;
  } icm_state_t;

  icm_state_t r_reg;
  icm_state_t r_next;
  logic [8:0] half_cnt;
  logic       cnt_done;
  logic       scl_fall;
  logic       wr1;
  logic       wr2;
  logic       wr3;
  logic       wr_start;
  logic       wr_stop;

  assign half_cnt = 9'((DIV_HALF(r_reg.cks)));
  assign cnt_done = (r_reg.cnt == 9'h0);
  assign scl_fall = r_reg.scl_d & ~r_reg.scl_s2;
  assign wr1      = bus_in.wr && bus_in.addr == icm_pkg::CTRL_TWO_IDX;
  assign wr2      = bus_in.wr && bus_in.addr == icm_pkg::XFER_MODE_IDX;
  assign wr3      = bus_in.wr && bus_in.addr == icm_pkg::IRQ_EN_IDX;
  assign wr_start = wr1 && bus_in.wdata[icm_pkg::BUS_BUSY_FLAG_BIT] && !bus_in.wdata[icm_pkg::SCP_BIT] && r_reg.master_select;
  assign wr_stop  = wr1 && !bus_in.wdata[icm_pkg::BUS_BUSY_FLAG_BIT] && !bus_in.wdata[icm_pkg::SCP_BIT] && r_reg.master_select;

  function automatic logic [9:0] DIV_HALF(input logic [3:0] code);
    DIV_HALF = (icm_pkg::DIV_TABLE[code] >> 1) - 10'd1;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    r_next        = r_reg;
    r_next.scl_s1 = scl_in;
    r_next.scl_s2 = r_reg.scl_s1;
    r_next.scl_d  = r_reg.scl_s2;
    r_next.sda_s1 = sda_in;
    r_next.sda_s2 = r_reg.sda_s1;
    r_next.sda_d  = r_reg.sda_s2;
    r_next.fs     = format_select_in;
    // register writes
    if (bus_in.wr && bus_in.addr == icm_pkg::CTRL_ONE_IDX) begin
      r_next.interface_enable  = bus_in.wdata[icm_pkg::ICE_BIT];
      r_next.rcvd = bus_in.wdata[icm_pkg::RCVD_BIT];
      r_next.master_select  = bus_in.wdata[icm_pkg::MST_BIT];
      r_next.transmit_select  = bus_in.wdata[icm_pkg::TRS_BIT];
      r_next.cks  = bus_in.wdata[3:0];
    end
    if (wr1) begin
      r_next.rst = bus_in.wdata[icm_pkg::RST_BIT];
      if (!bus_in.wdata[icm_pkg::SDA_DRIVE_WRITE_GUARD_BIT]) begin
        r_next.sda_drive_value = bus_in.wdata[icm_pkg::SDA_DRIVE_VALUE_BIT];
      end
    end
    if (wr2) begin
      r_next.lsb_first_select = bus_in.wdata[icm_pkg::MLS_BIT];
      if (!bus_in.wdata[icm_pkg::COUNT_WRITE_GUARD_BIT]) begin
        r_next.bc = bus_in.wdata[2:0];
      end
    end
    if (wr3) begin
      r_next.tx_empty_irq_enable  = bus_in.wdata[icm_pkg::TIE_BIT];
      r_next.tx_end_irq_enable = bus_in.wdata[icm_pkg::TX_END_IRQ_ENABLE_BIT];
      r_next.rx_full_irq_enable  = bus_in.wdata[icm_pkg::RIE_BIT];
    end
    // hardware mode changes come after writes, so the event wins
    // arbitration loss drops to slave receive
    if (arb_lost_in && r_reg.master_select && !r_reg.fs) begin
      r_next.master_select = 1'b0;
      r_next.transmit_select = 1'b0;
    end
    if (overrun_in && r_reg.master_select && !r_reg.transmit_select && r_reg.fs) begin
      r_next.master_select = 1'b0;
    end
    if (addr_byte_in && !r_reg.master_select && !r_reg.transmit_select && !r_reg.fs &&
        rx_byte_in[7:1] == own_address_in && rx_byte_in[0]) begin
      r_next.transmit_select = 1'b1;
    end
    // bus busy follows start and stop on the wire
    if (r_reg.scl_s2 && r_reg.sda_d && !r_reg.sda_s2) begin
      r_next.bus_busy_flag = 1'b1;
    end else if (r_reg.scl_s2 && !r_reg.sda_d && r_reg.sda_s2) begin
      r_next.bus_busy_flag = 1'b0;
    end
    // decrement mod 8 covers both 9 and 8 bit meanings
    if (scl_fall && r_reg.interface_enable && (r_reg.bus_busy_flag || r_reg.fs)) begin
      r_next.bc = r_reg.bc - icm_pkg::BC_ONE;
    end
    // transfer clock and start/stop sequencer
    r_next.cnt = cnt_done ? half_cnt : r_reg.cnt - 9'h1;
    case (r_reg.phase)
      icm_pkg::PH_IDLE: begin
        r_next.scl_lvl = 1'b1;
        r_next.sda_lvl = 1'b1;
        r_next.cnt     = half_cnt;
        if (wr_start && !r_reg.fs) begin
          r_next.phase = icm_pkg::PH_START;
        end else if (r_reg.master_select && r_reg.fs) begin
          r_next.phase = icm_pkg::PH_RUN;
        end
      end
      icm_pkg::PH_START: begin
        if (cnt_done) begin
          if (!r_reg.scl_lvl) begin
            r_next.scl_lvl = 1'b1;
            r_next.sda_lvl = 1'b1;
          end else if (r_reg.sda_lvl) begin
            r_next.sda_lvl = 1'b0;
          end else begin
            r_next.scl_lvl = 1'b0;
            r_next.phase   = icm_pkg::PH_RUN;
          end
        end
      end
      icm_pkg::PH_RUN: begin
        r_next.sda_lvl = 1'b1;
        // stretched clock holds the count until the wire agrees
        if (r_reg.scl_lvl && !r_reg.scl_s2 && !r_reg.fs) begin
          r_next.cnt = r_reg.cnt;
        end else if (cnt_done) begin
          r_next.scl_lvl = ~r_reg.scl_lvl;
        end
        if (wr_start && !r_reg.fs) begin
          r_next.phase = icm_pkg::PH_START;
          r_next.cnt   = half_cnt;
        end else if (wr_stop && !r_reg.fs) begin
          r_next.phase   = icm_pkg::PH_STOP;
          r_next.scl_lvl = 1'b0;
          r_next.sda_lvl = 1'b0;
          r_next.cnt     = half_cnt;
        end else if (r_reg.fs && !r_reg.master_select) begin
          r_next.phase = icm_pkg::PH_IDLE;
        end
      end
      icm_pkg::PH_STOP: begin
        r_next.sda_lvl = r_reg.sda_lvl;
        if (cnt_done) begin
          if (!r_reg.scl_lvl) begin
            r_next.scl_lvl = 1'b1;
          end else begin
            r_next.sda_lvl = 1'b1;
            r_next.phase   = icm_pkg::PH_IDLE;
          end
        end
      end
      default: begin
        r_next.phase = icm_pkg::PH_IDLE;
      end
    endcase
    // control reset clears sequencer and counter
    if (!r_next.interface_enable || r_next.rst || standby_in) begin
      r_next.phase   = icm_pkg::PH_IDLE;
      r_next.scl_lvl = 1'b1;
      r_next.sda_lvl = 1'b1;
      r_next.bc      = icm_pkg::BC_CLEAR;
    end
    // pin drive, registered from the next state
    // sync clock only as master
    r_next.scl_o  = r_next.fs & r_next.scl_lvl;
    r_next.scl_oe = r_next.interface_enable & (r_next.fs ? r_next.master_select : ~r_next.scl_lvl);
    r_next.sda_oe = r_next.interface_enable & ~(r_next.sda_drive_value & r_next.sda_lvl);
    r_next.irq = {r_next.tx_empty_irq_enable & flags_in.tx_empty, r_next.tx_end_irq_enable & flags_in.tx_end,
                  r_next.rx_full_irq_enable & flags_in.rx_full, r_next.rx_full_irq_enable & r_next.fs & flags_in.overrun};
    // read port
    r_next.rdata = 8'h00;
    if (bus_in.rd) begin
      case (bus_in.addr)
        icm_pkg::CTRL_ONE_IDX:  r_next.rdata = {r_reg.interface_enable, r_reg.rcvd, r_reg.master_select, r_reg.transmit_select, r_reg.cks};
        icm_pkg::CTRL_TWO_IDX:  r_next.rdata = {r_reg.bus_busy_flag & ~r_reg.fs, 1'b1, r_reg.sda_drive_value, 1'b1,
                                                r_reg.scl_lvl, 1'b1, r_reg.rst, 1'b1};
        icm_pkg::XFER_MODE_IDX: r_next.rdata = {r_reg.lsb_first_select, 3'h3, 1'b1, r_reg.bc};
        icm_pkg::IRQ_EN_IDX:    r_next.rdata = {r_reg.tx_empty_irq_enable, r_reg.tx_end_irq_enable, r_reg.rx_full_irq_enable, 5'h00};
        default:                r_next.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_reg         <= '0;
      r_reg.sda_drive_value    <= icm_pkg::CTRL_TWO_RST[icm_pkg::SDA_DRIVE_VALUE_BIT];
      r_reg.phase   <= icm_pkg::PH_IDLE;
      r_reg.scl_lvl <= 1'b1;
      r_reg.sda_lvl <= 1'b1;
      r_reg.scl_s1  <= 1'b1;
      r_reg.scl_s2  <= 1'b1;
      r_reg.scl_d   <= 1'b1;
      r_reg.sda_s1  <= 1'b1;
      r_reg.sda_s2  <= 1'b1;
      r_reg.sda_d   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign mode_out         = {r_reg.master_select, r_reg.transmit_select};
  assign rdata_out        = r_reg.rdata;
  assign scl_out          = r_reg.scl_o;
  assign scl_oe_out       = r_reg.scl_oe;
  assign sda_out          = 1'b0;
  assign sda_oe_out       = r_reg.sda_oe;
  assign lsb_first_out    = r_reg.lsb_first_select;
  assign bit_count_out    = r_reg.bc;
  assign tx_empty_irq_out = r_reg.irq[3];
  assign tx_end_irq_out   = r_reg.irq[2];
  assign rx_full_irq_out  = r_reg.irq[1];
  assign error_irq_out    = r_reg.irq[0];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  arb_loss_mode_a: assert property (arb_lost_in && r_reg.master_select && !r_reg.fs && !addr_byte_in
    |=> mode_out == icm_pkg::MODE_SLV_RX) else $error("arbitration loss kept master mode");
  addr_match_trs_a: assert property (addr_byte_in && mode_out == icm_pkg::MODE_SLV_RX && !r_reg.fs
    && rx_byte_in[7:1] == own_address_in && rx_byte_in[0] && !bus_in.wr |=> mode_out == icm_pkg::MODE_SLV_TX)
    else $error("address match did not set transmit");
  sync_overrun_a: assert property (overrun_in && mode_out == icm_pkg::MODE_MST_RX && r_reg.fs
    |=> !mode_out[1]) else $error("overrun kept master");
  sync_clock_a: assert property (r_reg.fs && !r_reg.master_select |-> !scl_oe_out)
    else $error("sync clock driven as slave");
  busy_read_a: assert property (bus_in.rd && bus_in.addr == icm_pkg::CTRL_TWO_IDX && r_reg.fs
    |=> !rdata_out[icm_pkg::BUS_BUSY_FLAG_BIT] && rdata_out[icm_pkg::SCP_BIT]) else $error("bad control two read");
  bus_start_a: assert property (r_reg.scl_s2 && $fell(r_reg.sda_s2) |=> r_reg.bus_busy_flag)
    else $error("start not seen as busy");
  count_guard_a: assert property (wr2 && bus_in.wdata[icm_pkg::COUNT_WRITE_GUARD_BIT] && !scl_fall
    && r_reg.interface_enable && !r_reg.rst && !standby_in && !r_next.rst |=> $stable(bit_count_out))
    else $error("guarded counter changed");
  // a counter write right after the reset bit drops is legal, so only the held reset is checked
  ctrl_reset_a: assert property (r_reg.rst |-> bit_count_out == icm_pkg::BC_CLEAR
    && r_reg.phase == icm_pkg::PH_IDLE) else $error("counter not cleared by control reset");
  start_issue_a: assert property (wr_start && !r_reg.fs && r_reg.interface_enable && !r_next.rst && !standby_in
    && (r_reg.phase == icm_pkg::PH_IDLE || r_reg.phase == icm_pkg::PH_RUN)
    |=> r_reg.phase == icm_pkg::PH_START) else $error("start not issued");
  stop_issue_a: assert property (wr_stop && !r_reg.fs && r_reg.interface_enable && !r_next.rst && !standby_in
    && r_reg.phase == icm_pkg::PH_RUN |=> r_reg.phase == icm_pkg::PH_STOP) else $error("stop not issued");
  no_issue_a: assert property (wr1 && bus_in.wdata[icm_pkg::SCP_BIT] && !r_reg.fs
    && r_reg.phase == icm_pkg::PH_IDLE |=> r_reg.phase == icm_pkg::PH_IDLE) else $error("disabled write issued");
  rx_irq_a: assert property (flags_in.rx_full && r_next.rx_full_irq_enable |=> rx_full_irq_out ##0
    (!flags_in.rx_full ##1 !rx_full_irq_out or flags_in.rx_full)) else $error("rx request wrong");
endmodule

// ---- testbench/icm_bus_peer.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// another device on the two-wire bus
// ---------------------------------------------------------------
module icm_bus_peer (
  input  wire logic clk_in,       // bench clock
  input  wire logic scl_oe_in,    // block drives SCL
  input  wire logic scl_drv_in,   // block SCL value
  input  wire logic sda_oe_in,    // block pulls SDA low
  output logic      scl_line_out, // resolved SCL wire
  output logic      sda_line_out  // resolved SDA wire
);
  logic sda_low_reg;
  logic scl_low_reg;
  initial begin
    sda_low_reg = 1'b0;
    scl_low_reg = 1'b0;
  end
  // pull-ups on both wires
  // a released wire floats high, never holds its last value
  assign sda_line_out = ~(sda_oe_in | sda_low_reg);
  assign scl_line_out = ~((scl_oe_in & ~scl_drv_in) | scl_low_reg);
  task automatic start_cond();
    @(posedge clk_in);
    sda_low_reg <= 1'b1;
  endtask
  task automatic stop_cond();
    @(posedge clk_in);
    sda_low_reg <= 1'b0;
  endtask
endmodule

// ---- testbench/i2c_control_mode_registers_bench.sv ----
`timescale 1ns/1ps
module i2c_control_mode_registers_bench;
  typedef struct packed {
    logic [7:0] exp;
    logic [7:0] mask;
  } icm_note_t;
  logic                  clk_in;
  logic                  reset_n_in;
  icm_pkg::icm_bus_req_t bus_in;
  logic [7:0]            rdata_out;
  logic                  format_select_in;
  logic [6:0]            own_address_in;
  logic                  addr_byte_in;
  logic [7:0]            rx_byte_in;
  logic                  arb_lost_in;
  logic                  overrun_in;
  logic                  standby_in;
  icm_pkg::icm_flags_t   flags_in;
  logic                  scl_out;
  logic                  scl_oe_out;
  logic                  sda_out;
  logic                  sda_oe_out;
  logic [1:0]            mode_out;
  logic                  lsb_first_out;
  logic [2:0]            bit_count_out;
  logic                  tx_empty_irq_out;
  logic                  tx_end_irq_out;
  logic                  rx_full_irq_out;
  logic                  error_irq_out;
  logic                  scl_line;
  logic                  sda_line;
  logic                  rd_seen;
  logic [31:0]           seed;
  logic [7:0]            v;
  icm_note_t             note;
  icm_note_t             notes[$];
  int                    fail_count;
  int                    checks;
  int                    cyc;
  int                    n;
  int                    half;
  int                    divs[16] = '{28, 40, 48, 64, 80, 100, 112, 128, 112, 160, 192, 256, 320, 400, 448, 512};
  int                    codes[4] = '{0, 7, 8, 15};
  icm_ctrl dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus_in), .rdata_out(rdata_out),
    .format_select_in(format_select_in), .own_address_in(own_address_in), .addr_byte_in(addr_byte_in),
    .rx_byte_in(rx_byte_in), .arb_lost_in(arb_lost_in), .overrun_in(overrun_in), .standby_in(standby_in),
    .flags_in(flags_in), .scl_in(scl_line), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .mode_out(mode_out), .lsb_first_out(lsb_first_out),
    .bit_count_out(bit_count_out), .tx_empty_irq_out(tx_empty_irq_out), .tx_end_irq_out(tx_end_irq_out),
    .rx_full_irq_out(rx_full_irq_out), .error_irq_out(error_irq_out));
  icm_bus_peer peer (.clk_in(clk_in), .scl_oe_in(scl_oe_out), .scl_drv_in(scl_out), .sda_oe_in(sda_oe_out),
    .scl_line_out(scl_line), .sda_line_out(sda_line));
  always #12.5 clk_in = ~clk_in;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic wr_reg(input logic [1:0] idx, input logic [7:0] val);
    @(posedge clk_in);
    bus_in <= '{wr: 1'b1, rd: 1'b0, addr: idx, wdata: val};
    @(posedge clk_in);
    bus_in <= '0;
  endtask
  task automatic rd_reg(input logic [1:0] idx, input logic [7:0] val, input logic [7:0] msk);
    notes.push_back('{exp: val, mask: msk});
    @(posedge clk_in);
    bus_in <= '{wr: 1'b0, rd: 1'b1, addr: idx, wdata: 8'h00};
    @(posedge clk_in);
    bus_in <= '0;
  endtask
  task automatic pulse(input int which);
    @(posedge clk_in);
    case (which)
      0: arb_lost_in <= 1'b1;
      1: overrun_in <= 1'b1;
      2: addr_byte_in <= 1'b1;
      default: standby_in <= 1'b1;
    endcase
    @(posedge clk_in);
    {arb_lost_in, overrun_in, addr_byte_in, standby_in} <= 4'h0;
    idle(2);
  endtask
  task automatic wait_for(input logic on_sda, input logic lvl, output int k);
    k = 0;
    while (((on_sda ? sda_oe_out : scl_line) !== lvl) && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 3000) chk(8'h1, 8'h0, "wait limit");
  endtask
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // read data stands only in the cycle after the strobe
  always @(posedge clk_in) rd_seen <= bus_in.rd;
  always @(negedge clk_in) begin
    if (rd_seen) begin
      note = notes.pop_front();
      chk(rdata_out & note.mask, note.exp & note.mask, "read data");
    end
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    bus_in = '0;
    {format_select_in, own_address_in, addr_byte_in, rx_byte_in} = 17'h0;
    {arb_lost_in, overrun_in, standby_in, flags_in, rd_seen} = 8'h0;
    seed = 32'h6e0e;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_reg(0, 8'h00, 8'hff);
    rd_reg(1, 8'h7d, 8'hff);
    rd_reg(2, 8'h38, 8'hff);
    rd_reg(3, 8'h00, 8'hff);
    $display("test reset values done");
    for (int m = 0; m < 4; m++) begin
      seed = lfsr_step(seed);
      v = {2'b10, m[1:0], seed[3:0]};
      wr_reg(0, v);
      idle(1);
      chk(8'(mode_out), 8'(m[1:0]), "mode code");
      rd_reg(0, v, 8'hff);
    end
    wr_reg(0, 8'hb0);
    pulse(0);
    chk(8'(mode_out), 8'h0, "arbitration loss");
    @(posedge clk_in) format_select_in <= 1'b1;
    wr_reg(0, 8'ha0);
    idle(2);
    chk(8'(scl_oe_out), 8'h1, "sync master clock drive");
    wait_for(1'b0, 1'b0, n);
    chk(8'(scl_out), 8'h0, "sync clock low");
    pulse(1);
    chk(8'(mode_out), 8'h0, "overrun as master");
    chk(8'(scl_oe_out), 8'h0, "slave clock drive");
    @(posedge clk_in) format_select_in <= 1'b0;
    seed = lfsr_step(seed);
    own_address_in <= seed[6:0];
    wr_reg(0, 8'h80);
    rx_byte_in <= {seed[6:0] ^ 7'h01, 1'b1};
    pulse(2);
    chk(8'(mode_out), 8'h0, "address mismatch");
    @(posedge clk_in) rx_byte_in <= {seed[6:0], 1'b0};
    pulse(2);
    chk(8'(mode_out), 8'h0, "address with write");
    @(posedge clk_in) rx_byte_in <= {seed[6:0], 1'b1};
    pulse(2);
    chk(8'(mode_out), 8'h1, "address with read");
    $display("test modes done");
    wr_reg(0, 8'h00);
    wr_reg(1, 8'h4d);
    idle(1);
    chk(8'(sda_oe_out), 8'h0, "halted pin");
    wr_reg(0, 8'h80);
    wr_reg(1, 8'h4d);
    idle(1);
    chk(8'(sda_oe_out), 8'h1, "sda pulled low");
    chk(8'(sda_out), 8'h0, "sda drive level");
    rd_reg(1, 8'h5d, 8'h7f);
    wr_reg(1, 8'h7d);
    idle(1);
    chk(8'(sda_oe_out), 8'h1, "guarded sda write");
    wr_reg(1, 8'h6d);
    idle(1);
    chk(8'(sda_oe_out), 8'h0, "sda released");
    wr_reg(0, 8'hb0);
    wr_reg(1, 8'hfd);
    idle(40);
    chk(8'(sda_oe_out), 8'h0, "no start when disabled");
    rd_reg(1, 8'h7d, 8'hff);
    $display("test sda control done");
    wr_reg(2, 8'h0d);
    rd_reg(2, 8'h38, 8'hff);
    wr_reg(2, 8'h85);
    idle(1);
    chk(8'(lsb_first_out), 8'h1, "bit order");
    chk(8'(bit_count_out), 8'h5, "count port");
    rd_reg(2, 8'hbd, 8'hff);
    wr_reg(1, 8'h7f);
    rd_reg(2, 8'hb8, 8'hff);
    wr_reg(1, 8'h7d);
    wr_reg(2, 8'h05);
    pulse(3);
    rd_reg(2, 8'h38, 8'hff);
    $display("test bit counter done");
    wr_reg(0, 8'h80);
    peer.start_cond();
    idle(6);
    rd_reg(1, 8'h80, 8'h80);
    peer.stop_cond();
    idle(6);
    rd_reg(1, 8'h00, 8'h80);
    format_select_in <= 1'b1;
    peer.start_cond();
    idle(6);
    rd_reg(1, 8'h00, 8'h80);
    peer.stop_cond();
    format_select_in <= 1'b0;
    $display("test bus busy done");
    for (int k = 0; k < 4; k++) begin
      half = divs[codes[k]] / 2;
      wr_reg(0, {4'hb, 4'(codes[k])});
      wr_reg(1, 8'hbd);
      wait_for(1'b1, 1'b1, n);
      wait_for(1'b0, 1'b0, n);
      chk(8'(n >= half - 1 && n <= half + 1), 8'h1, "start spacing");
      if (half > 40) rd_reg(1, 8'h80, 8'h88);
      wr_reg(1, 8'h3d);
      wait_for(1'b1, 1'b1, n);
      n = 0;
      for (int t = 0; t < 3000 && sda_oe_out === 1'b1; t++) begin
        n = scl_line ? n + 1 : 0;
        @(negedge clk_in);
      end
      chk(8'(n >= half - 1 && n <= half + 1), 8'h1, "stop spacing");
      idle(6);
      rd_reg(1, 8'h00, 8'h80);
    end
    $display("test start and stop done");
    wr_reg(0, 8'h80);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr_step(seed);
      format_select_in <= seed[4];
      flags_in <= '{tx_empty: seed[0], tx_end: seed[1], rx_full: seed[2], overrun: seed[3] & seed[4]};
      wr_reg(3, seed[15:8]);
      idle(3);
      chk(8'(tx_empty_irq_out), 8'(seed[0] & seed[15]), "tx empty request");
      chk(8'(tx_end_irq_out), 8'(seed[1] & seed[14]), "tx end request");
      chk(8'(rx_full_irq_out), 8'(seed[2] & seed[13]), "rx full request");
      chk(8'(error_irq_out), 8'(seed[3] & seed[4] & seed[13]), "overrun");
      rd_reg(3, {seed[15:13], 5'h00}, 8'hff);
    end
    $display("test interrupts done");
    idle(4);
    give_verdict();
  end
endmodule
